// ### rtl/uerx_fifo.sv
// receive fifo for the usb function endpoints, with endpoint-indexed registers
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1 - flush bit empties fifo, resets flags (empty set), then self-clears.
// R2 - wait-state bit adds one wait cycle to core reads of the data port.
// R3 - firmware sets read-complete after a full set; set-present flag then clears.
// R4 - read-complete bit self-clears once the set-present flag is cleared.
// R5 - read-complete acts only while both setup overwrite flags are clear.
// R6 - auto mode: ack advances marker; nak reverses pointer, or advances if isochronous.
// R7 - manual advance bit moves marker to next set origin, then self-clears.
// R8 - advance acts only with reverse, auto and flush bits clear.
// R9 - manual reverse bit returns write pointer to marker, then self-clears.
// R10 - reverse acts only with advance, auto and flush bits clear.
// R11 - writes and reads through the data port bump write and read pointers.
// R12 - full flag tracks wrapped-and-equal pointers, read-only, never sticky.
// R13 - underrun sets on reading an empty fifo or an absent byte count.
// R14 - underrun is cleared only by firmware.
// R15 - on underrun the read pointer stays at the empty position.
// R16 - isochronous underrun still updates at once; usb events wait for frame start.
// R17 - overrun sets on write to full fifo or count write with both sets present.
// R18 - a setup packet after an overrun clears the overrun flag.
// R19 - on overrun the write pointer stays at the full position.
// R20 - isochronous overrun posts only at the next start of frame.
// R21 - setup end-overwrite flag locks fifo state until firmware clears it.
// R22 - byte count is ten bits on endpoint one, five bits elsewhere, upper zero.
module uerx_fifo
    import uerx_pkg::*;
#(
    parameter int NUM_EP  = 3,
    parameter int DEPTH   = 16,
    parameter int WIDE_EP = 1
)
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // core register port
    input  wire uerx_sfr_s            sfr_req,
    input  wire logic [UERX_EP_W-1:0] endpoint_select,
    output logic                      sfr_ready,
    output logic [7:0]                sfr_rdata,
    output logic                      sfr_rvalid,
    // function interface unit
    input  wire uerx_fiu_s            fiu_req,
    // setup overwrite locks, one bit per endpoint
    input  wire logic [NUM_EP-1:0]    setup_start_overwrite,
    input  wire logic [NUM_EP-1:0]    setup_end_overwrite
);

    localparam int         PW      = $clog2(DEPTH);
    localparam logic [PW:0] PTR_ONE = (PW+1)'(1);

    ////////////////////////////////////////////////////////////////////////////
    // core access decode and wait state

    logic                    wait_done_r;
    logic                    sel_ws;
    logic                    need_wait;
    logic                    acc_rd;
    logic                    acc_wr;
    logic [7:0]              rd_mux;
    logic [7:0]              rdata_r;
    logic                    rvalid_r;
    logic [NUM_EP-1:0]       ep_ws;
    logic [NUM_EP-1:0][7:0]  ep_data;
    logic [NUM_EP-1:0][7:0]  ep_ctrl;
    logic [NUM_EP-1:0][7:0]  ep_flag;
    logic [NUM_EP-1:0][7:0]  ep_cntl;
    logic [NUM_EP-1:0][7:0]  ep_cnth;

    always_comb
    begin
        sel_ws = 1'b0;
        if (int'(endpoint_select) < NUM_EP)
        begin
            sel_ws = ep_ws[endpoint_select];
        end
    end

    assign need_wait = sfr_req.rd && (sfr_req.addr == UERX_DATA_ADDR) && sel_ws;
    assign sfr_ready = !need_wait || wait_done_r; // R2
    assign acc_rd    = sfr_req.rd && sfr_ready;
    assign acc_wr    = sfr_req.wr;

    // one stalled cycle per data read while the wait-state bit is set
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_done_r <= 1'b0;
        end
        else
        begin
            wait_done_r <= need_wait && !wait_done_r; // R2
        end
    end

    always_comb
    begin
        rd_mux = 8'h00;
        if (int'(endpoint_select) < NUM_EP)
        begin
            unique case (sfr_req.addr)
                UERX_DATA_ADDR: rd_mux = ep_data[endpoint_select];
                UERX_CTRL_ADDR: rd_mux = ep_ctrl[endpoint_select];
                UERX_FLAG_ADDR: rd_mux = ep_flag[endpoint_select];
                UERX_CNTL_ADDR: rd_mux = ep_cntl[endpoint_select];
                UERX_CNTH_ADDR: rd_mux = ep_cnth[endpoint_select];
                default:        rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= acc_rd;
            rdata_r  <= acc_rd ? rd_mux : rdata_r;
        end
    end

    assign sfr_rdata  = rdata_r;
    assign sfr_rvalid = rvalid_r;

    ////////////////////////////////////////////////////////////////////////////
    // per-endpoint receive fifo

    for (genvar e = 0; e < NUM_EP; e++)
    begin : g_ep
        logic [7:0]            mem_r [DEPTH];
        logic [PW:0]           wp_r;
        logic [PW:0]           rp_r;
        logic [PW:0]           wm_r;
        logic                  clr_r;
        logic                  ws_r;
        logic                  ffrc_r;
        logic                  iso_r;
        logic                  arm_r;
        logic                  adv_r;
        logic                  rev_r;
        logic [1:0]            pres_r;
        logic                  ciw_r;
        logic                  cir_r;
        logic [UERX_CNT_W-1:0] cnt_r [2];
        logic                  urf_r;
        logic                  ovf_r;
        logic                  pend_pres_r;
        logic                  pend_ovf_r;
        logic [UERX_CNT_W-1:0] cnt_in;
        logic [UERX_CNT_W-1:0] cnt_cur;
        logic                  cpu_sel;
        logic                  fiu_sel;
        logic                  ctrl_wr;
        logic                  flag_wr;
        logic                  rd_data;
        logic                  rd_cnt;
        logic                  empty;
        logic                  full;
        logic                  f_wr;
        logic                  f_cnt;
        logic                  f_end;
        logic                  ovf_cnt;
        logic                  ovf_evt;
        logic                  ovf_post;
        logic                  urf_evt;
        logic                  auto_adv;
        logic                  auto_rev;
        logic                  man_adv;
        logic                  man_rev;
        logic                  mark;
        logic                  pres_set;
        logic                  release_set;

        assign cpu_sel = (endpoint_select == UERX_EP_W'(e));
        assign fiu_sel = (fiu_req.ep == UERX_EP_W'(e));
        assign ctrl_wr = acc_wr && cpu_sel && (sfr_req.addr == UERX_CTRL_ADDR);
        assign flag_wr = acc_wr && cpu_sel && (sfr_req.addr == UERX_FLAG_ADDR);
        assign rd_data = acc_rd && cpu_sel && (sfr_req.addr == UERX_DATA_ADDR);
        assign rd_cnt  = acc_rd && cpu_sel && (sfr_req.addr == UERX_CNTL_ADDR);
        assign f_wr    = fiu_req.wr && fiu_sel;
        assign f_cnt   = fiu_req.cnt_wr && fiu_sel;
        assign f_end   = fiu_req.pkt_end && fiu_sel;

        assign empty = (wp_r == rp_r);
        assign full  = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]); // R12

        assign ovf_cnt  = f_cnt && (pres_r == 2'b11);       // R17
        assign ovf_evt  = (f_wr && full) || ovf_cnt;        // R17
        assign ovf_post = iso_r ? (fiu_req.sof && pend_ovf_r) : ovf_evt; // R20
        assign urf_evt  = (rd_data && empty) || (rd_cnt && (pres_r == 2'b00)); // R13 R16

        assign auto_adv = arm_r && f_end && (fiu_req.ack || iso_r);   // R6
        assign auto_rev = arm_r && f_end && !fiu_req.ack && !iso_r;   // R6
        assign man_adv  = adv_r && !rev_r && !arm_r && !clr_r;        // R7 R8
        assign man_rev  = rev_r && !adv_r && !arm_r && !clr_r;        // R9 R10
        assign mark     = auto_adv || man_adv;
        // usb-caused set arrivals wait for the frame start in isochronous mode
        assign pres_set = iso_r ? (fiu_req.sof && pend_pres_r) : mark; // R16
        assign release_set = ffrc_r && !setup_start_overwrite[e]
                           && !setup_end_overwrite[e]; // R3 R5

        // counts keep only the bits that exist on this endpoint
        assign cnt_in  = (e == WIDE_EP) ? fiu_req.cnt
                       : {{(UERX_CNT_W-UERX_CNT_NARROW){1'b0}},
                          fiu_req.cnt[UERX_CNT_NARROW-1:0]}; // R22
        assign cnt_cur = cnt_r[cir_r];

        // pointers and write marker
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                wp_r <= '0;
                rp_r <= '0;
                wm_r <= '0;
            end
            else if (clr_r)
            begin
                wp_r <= '0; // R1
                rp_r <= '0;
                wm_r <= '0;
            end
            else
            begin
                if (man_rev || auto_rev)
                begin
                    wp_r <= wm_r; // R6 R9
                end
                else if (f_wr && !full)
                begin
                    wp_r <= wp_r + PTR_ONE; // R11 R19
                end
                wm_r <= mark ? wp_r : wm_r; // R6 R7
                // locked state and empty fifo both leave the read pointer alone
                if (rd_data && !empty && !setup_end_overwrite[e])
                begin
                    rp_r <= rp_r + PTR_ONE; // R11 R15 R21
                end
            end
        end

        always_ff @(posedge sys_clk)
        begin
            if (f_wr && !full)
            begin
                mem_r[wp_r[PW-1:0]] <= fiu_req.data; // R11
            end
        end

        // control register
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                clr_r  <= UERX_CTRL_RESET[UERX_CTRL_CLR];
                ws_r   <= UERX_CTRL_RESET[UERX_CTRL_WS];
                ffrc_r <= UERX_CTRL_RESET[UERX_CTRL_FFRC];
                iso_r  <= UERX_CTRL_RESET[UERX_CTRL_ISO];
                arm_r  <= UERX_CTRL_RESET[UERX_CTRL_ARM];
                adv_r  <= UERX_CTRL_RESET[UERX_CTRL_ADV];
                rev_r  <= UERX_CTRL_RESET[UERX_CTRL_REV];
            end
            else if (ctrl_wr)
            begin
                clr_r  <= sfr_req.wdata[UERX_CTRL_CLR];
                ws_r   <= sfr_req.wdata[UERX_CTRL_WS];
                ffrc_r <= sfr_req.wdata[UERX_CTRL_FFRC];
                iso_r  <= sfr_req.wdata[UERX_CTRL_ISO];
                arm_r  <= sfr_req.wdata[UERX_CTRL_ARM];
                adv_r  <= sfr_req.wdata[UERX_CTRL_ADV];
                rev_r  <= sfr_req.wdata[UERX_CTRL_REV];
            end
            else
            begin
                clr_r  <= 1'b0; // R1
                ffrc_r <= ffrc_r && !release_set; // R4
                adv_r  <= adv_r && !man_adv; // R7
                rev_r  <= rev_r && !man_rev; // R9
            end
        end

        // data sets and byte count ring
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                pres_r      <= 2'b00;
                ciw_r       <= 1'b0;
                cir_r       <= 1'b0;
                pend_pres_r <= 1'b0;
                cnt_r[0]    <= '0;
                cnt_r[1]    <= '0;
            end
            else if (clr_r)
            begin
                pres_r      <= 2'b00; // R1
                ciw_r       <= 1'b0;
                cir_r       <= 1'b0;
                pend_pres_r <= 1'b0;
            end
            else
            begin
                if (f_cnt && !ovf_cnt)
                begin
                    cnt_r[ciw_r] <= cnt_in; // R22
                end
                pend_pres_r <= (iso_r && mark) ? 1'b1
                             : (fiu_req.sof ? 1'b0 : pend_pres_r); // R16
                if (pres_set)
                begin
                    pres_r[ciw_r] <= 1'b1;
                    ciw_r         <= !ciw_r;
                end
                // set-present is hardware-owned; firmware releases through read-complete
                if (release_set && !setup_end_overwrite[e])
                begin
                    pres_r[cir_r] <= 1'b0; // R3 R21
                    cir_r         <= !cir_r;
                end
            end
        end

        // error flags: a hardware set wins over a firmware write in the same cycle
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                urf_r      <= UERX_FLAG_RESET[UERX_FLAG_URF];
                ovf_r      <= UERX_FLAG_RESET[UERX_FLAG_OVF];
                pend_ovf_r <= 1'b0;
            end
            else if (clr_r)
            begin
                urf_r      <= 1'b0; // R1
                ovf_r      <= 1'b0;
                pend_ovf_r <= 1'b0;
            end
            else
            begin
                urf_r <= urf_evt // R13 R16
                      || (flag_wr ? sfr_req.wdata[UERX_FLAG_URF] : urf_r); // R14
                pend_ovf_r <= (iso_r && ovf_evt) ? 1'b1
                            : (fiu_req.sof ? 1'b0 : pend_ovf_r); // R20
                ovf_r <= ovf_post // R17 R20
                      || (!(fiu_req.setup && fiu_sel) // R18
                          && (flag_wr ? sfr_req.wdata[UERX_FLAG_OVF] : ovf_r));
            end
        end

        assign ep_ws[e]   = ws_r;
        assign ep_data[e] = mem_r[rp_r[PW-1:0]];
        assign ep_ctrl[e] = {clr_r, 1'b0, ws_r, ffrc_r, iso_r, arm_r, adv_r, rev_r};
        assign ep_flag[e] = {pres_r[1], pres_r[0], 2'b00, empty, full, urf_r, ovf_r}; // R12
        assign ep_cntl[e] = cnt_cur[7:0];
        assign ep_cnth[e] = {6'h00, cnt_cur[UERX_CNT_W-1:8]}; // R22
    end

endmodule // uerx_fifo

// ### inc/uerx_pkg.sv
// shared constants and carrier types for the usb endpoint receive fifo
package uerx_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // special function register addresses
    localparam logic [7:0] UERX_DATA_ADDR  = 8'he3;
    localparam logic [7:0] UERX_CTRL_ADDR  = 8'he4;
    localparam logic [7:0] UERX_FLAG_ADDR  = 8'he5;
    localparam logic [7:0] UERX_CNTL_ADDR  = 8'he6;
    localparam logic [7:0] UERX_CNTH_ADDR  = 8'he7;

    ////////////////////////////////////////////////////////////////////////////
    // rx_fifo_control fields
    localparam int         UERX_CTRL_CLR   = 7;
    localparam int         UERX_CTRL_WS    = 5;
    localparam int         UERX_CTRL_FFRC  = 4;
    localparam int         UERX_CTRL_ISO   = 3;
    localparam int         UERX_CTRL_ARM   = 2;
    localparam int         UERX_CTRL_ADV   = 1;
    localparam int         UERX_CTRL_REV   = 0;
    localparam logic [7:0] UERX_CTRL_RESET = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // rx_fifo_flags fields
    localparam int         UERX_FLAG_PHI   = 7;
    localparam int         UERX_FLAG_PLO   = 6;
    localparam int         UERX_FLAG_EMP   = 3;
    localparam int         UERX_FLAG_FULL  = 2;
    localparam int         UERX_FLAG_URF   = 1;
    localparam int         UERX_FLAG_OVF   = 0;
    localparam logic [7:0] UERX_FLAG_RESET = 8'h08;

    ////////////////////////////////////////////////////////////////////////////
    // byte count layout and endpoint index
    localparam int         UERX_CNT_W      = 10;
    localparam int         UERX_CNT_NARROW = 5;
    localparam int         UERX_EP_W       = 2;
    localparam int         UERX_WAIT_CYC   = 1;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [7:0]            addr;
        logic [7:0]            wdata;
    } uerx_sfr_s;

    typedef struct packed {
        logic [UERX_EP_W-1:0]  ep;
        logic                  wr;
        logic [7:0]            data;
        logic                  cnt_wr;
        logic [UERX_CNT_W-1:0] cnt;
        logic                  pkt_end;
        logic                  ack;
        logic                  setup;
        logic                  sof;
    } uerx_fiu_s;

endpackage

// ### verification/uerx_fifo_properties.sv
// checker on the receive fifo register port
`timescale 1ns/1ps
module uerx_fifo_chk
    import uerx_pkg::*;
#(
    parameter int NUM_EP  = 3,
    parameter int WIDE_EP = 1
)
(
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rstn,
    // core register port
    input wire uerx_sfr_s            sfr_req,
    input wire logic [UERX_EP_W-1:0] endpoint_select,
    input wire logic                 sfr_ready,
    input wire logic [7:0]           sfr_rdata,
    input wire logic                 sfr_rvalid,
    // link and locks
    input wire uerx_fiu_s            fiu_req,
    input wire logic [NUM_EP-1:0]    setup_start_overwrite,
    input wire logic [NUM_EP-1:0]    setup_end_overwrite
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic taken;
    assign taken = sfr_req.rd && sfr_ready;

    ////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (taken |=> sfr_rvalid)
        else $error("read not answered");
    a_answer_cause: assert property (sfr_rvalid |-> $past(taken))
        else $error("answer without a read");
    a_wait_cause: assert property (!sfr_ready |-> sfr_req.rd && sfr_req.addr == UERX_DATA_ADDR)
        else $error("wait outside a data read");
    a_wait_single: assert property (!sfr_ready |=> sfr_ready)
        else $error("more than one wait");
    a_rdata_hold: assert property (!sfr_rvalid |-> $stable(sfr_rdata))
        else $error("read data moved");
    a_count_high: assert property (sfr_rvalid && $past(sfr_req.addr) == UERX_CNTH_ADDR
        |-> sfr_rdata[7:2] == 6'h00 && ($past(endpoint_select) == WIDE_EP || sfr_rdata == 8'h00))
        else $error("count high reserved bits");
    a_count_narrow: assert property (sfr_rvalid && $past(sfr_req.addr) == UERX_CNTL_ADDR
        && $past(endpoint_select) != WIDE_EP |-> sfr_rdata[7:5] == 3'h0)
        else $error("narrow count too wide");
    a_flag_shape: assert property (sfr_rvalid && $past(sfr_req.addr) == UERX_FLAG_ADDR
        |-> sfr_rdata[5:4] == 2'h0 && !(sfr_rdata[3] && sfr_rdata[2]))
        else $error("flag register shape");
    a_unmapped_zero: assert property (sfr_rvalid && ($past(sfr_req.addr) < UERX_DATA_ADDR
        || $past(sfr_req.addr) > UERX_CNTH_ADDR) |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");

    c_waited: cover property (!sfr_ready ##1 sfr_ready ##1 sfr_rvalid);
    c_full: cover property (sfr_rvalid && $past(sfr_req.addr) == UERX_FLAG_ADDR && sfr_rdata[2]);
    c_count: cover property (sfr_rvalid && $past(sfr_req.addr) == UERX_CNTH_ADDR);
endmodule // uerx_fifo_chk

bind uerx_fifo uerx_fifo_chk #(.NUM_EP(NUM_EP), .WIDE_EP(WIDE_EP)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req), .endpoint_select(endpoint_select),
    .sfr_ready(sfr_ready), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .fiu_req(fiu_req), .setup_start_overwrite(setup_start_overwrite),
    .setup_end_overwrite(setup_end_overwrite)
);

// ### verification/uerx_fiu_model.sv
// function interface unit model driving the receive link
`timescale 1ns/1ps
module uerx_fiu_model
    import uerx_pkg::*;
(
    // clock
    input  wire logic sys_clk,
    // link
    output uerx_fiu_s fiu_req
);
    initial fiu_req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // kind: 0 byte, 1 count, 2 packet end (v[0] ack), 3 setup, 4 frame start
    task automatic put(input logic [UERX_EP_W-1:0] ep, input int kind, input logic [9:0] v);
        uerx_fiu_s p;
        p         = '0;
        p.ep      = ep;
        p.wr      = (kind == 0);
        p.data    = v[7:0];
        p.cnt_wr  = (kind == 1);
        p.cnt     = v;
        p.pkt_end = (kind == 2);
        p.ack     = v[0];
        p.setup   = (kind == 3);
        p.sof     = (kind == 4);
        @(posedge sys_clk);
        #1;
        fiu_req = p;
        @(posedge sys_clk);
        #1;
        fiu_req = '0;
    endtask
endmodule // uerx_fiu_model

// ### verification/uerx_fifo_tb.sv
// self-checking bench for the usb endpoint receive fifo
`timescale 1ns/1ps
module uerx_fifo_tb
    import uerx_pkg::*;
;
    logic       sys_clk;
    logic       rstn;
    uerx_sfr_s  sfr_req;
    logic [1:0] es;
    logic       sfr_ready;
    logic [7:0] sfr_rdata;
    logic       sfr_rvalid;
    uerx_fiu_s  fiu_req;
    logic [2:0] seo;
    logic [2:0] sso;
    int         fails;
    int         checks_done;
    int         waits;
    logic [7:0] d;

    uerx_fifo u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req), .endpoint_select(es),
        .sfr_ready(sfr_ready), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
        .fiu_req(fiu_req), .setup_start_overwrite(sso), .setup_end_overwrite(seo)
    );
    uerx_fiu_model fm (.sys_clk(sys_clk), .fiu_req(fiu_req));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_req.addr  = a;
        sfr_req.wdata = v;
        sfr_req.wr    = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_req.wr = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // read held until ready, data taken with the answer
    task automatic rd(input logic [7:0] a);
        waits        = 0;
        sfr_req.addr = a;
        sfr_req.rd   = 1'b1;
        @(negedge sys_clk);
        while (sfr_ready !== 1'b1 && waits < 8)
        begin
            @(negedge sys_clk);
            waits++;
        end
        @(posedge sys_clk);
        #1;
        sfr_req.rd = 1'b0;
        d = (sfr_rvalid === 1'b1) ? sfr_rdata : 8'hxx;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk,
                      input string n);
        rd(a);
        chk(n, e, d & mk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #(25 * 8000);
        fails++;
        tally_and_finish;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        fails = 0;
        checks_done = 0;
        rstn = 1'b0;
        sfr_req = '0;
        es = 2'h0;
        seo = 3'h0;
        sso = 3'h0;
        repeat (20) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            es = i[1:0];
            rc(UERX_CTRL_ADDR, UERX_CTRL_RESET, 8'hff, "ctrl");
            rc(UERX_FLAG_ADDR, UERX_FLAG_RESET, 8'hff, "flag");
            rc(UERX_CNTH_ADDR, 8'h00, 8'hff, "count");
        end
        wr(8'he0, 8'hff);
        rc(8'he0, 8'h00, 8'hff, "unmapped");
        // acknowledged packet on the wide endpoint
        es = 2'h1;
        for (int i = 0; i < 3; i++)
            fm.put(2'h1, 0, 10'h0a0 + 10'(i));
        fm.put(2'h1, 1, 10'h2c3);
        fm.put(2'h1, 2, 10'h001);
        rd(UERX_FLAG_ADDR);
        chk("present", 8'h01, {7'h0, |d[7:6]});
        chk("flag", 8'h00, d & 8'h0f);
        rc(UERX_CNTL_ADDR, 8'hc3, 8'hff, "cntl");
        rc(UERX_CNTH_ADDR, 8'h02, 8'hff, "cnth");
        for (int i = 0; i < 3; i++)
            rc(UERX_DATA_ADDR, 8'ha0 + 8'(i), 8'hff, "data");
        chk("nowait", 8'h00, 8'(waits));
        wr(UERX_CTRL_ADDR, 8'h14);
        rc(UERX_FLAG_ADDR, 8'h08, 8'hff, "released");
        rc(UERX_CTRL_ADDR, 8'h04, 8'hff, "ctrl");
        // underrun by data and by count
        rd(UERX_DATA_ADDR);
        rc(UERX_FLAG_ADDR, 8'h0a, 8'hff, "urf");
        fm.put(2'h1, 0, 10'h05a);
        rc(UERX_DATA_ADDR, 8'h5a, 8'hff, "held");
        rc(UERX_FLAG_ADDR, 8'h0a, 8'hff, "urf");
        wr(UERX_FLAG_ADDR, 8'h00);
        rd(UERX_CNTL_ADDR);
        rc(UERX_FLAG_ADDR, 8'h0a, 8'hff, "urf");
        // lock holds the release back
        fm.put(2'h1, 0, 10'h011);
        fm.put(2'h1, 1, 10'h001);
        fm.put(2'h1, 2, 10'h001);
        seo = 3'h2;
        sso = 3'h2;
        wr(UERX_CTRL_ADDR, 8'h14);
        rc(UERX_FLAG_ADDR, 8'h80, 8'hc0, "locked");
        rc(UERX_DATA_ADDR, 8'h11, 8'hff, "locked");
        rc(UERX_CTRL_ADDR, 8'h14, 8'hff, "ctrl");
        seo = 3'h0;
        rc(UERX_FLAG_ADDR, 8'h80, 8'hc0, "startlock");
        sso = 3'h0;
        rc(UERX_DATA_ADDR, 8'h11, 8'hff, "unlocked");
        rc(UERX_FLAG_ADDR, 8'h00, 8'hc0, "freed");
        rc(UERX_CTRL_ADDR, 8'h04, 8'hff, "ctrl");
        // fill, overrun, setup clear, flush on a narrow endpoint
        es = 2'h0;
        for (int i = 0; i < 16; i++)
            fm.put(2'h0, 0, 10'(i));
        rc(UERX_FLAG_ADDR, 8'h04, 8'h0f, "full");
        fm.put(2'h0, 0, 10'h0ee);
        rc(UERX_FLAG_ADDR, 8'h05, 8'h0f, "ovf");
        rc(UERX_DATA_ADDR, 8'h00, 8'hff, "data");
        rc(UERX_FLAG_ADDR, 8'h01, 8'h0f, "unfull");
        for (int i = 1; i < 16; i++)
            rc(UERX_DATA_ADDR, 8'(i), 8'hff, "data");
        fm.put(2'h0, 3, 10'h000);
        rc(UERX_FLAG_ADDR, 8'h00, 8'h01, "setup");
        wr(UERX_CTRL_ADDR, 8'h84);
        rc(UERX_FLAG_ADDR, 8'h08, 8'hff, "flush");
        rc(UERX_CTRL_ADDR, 8'h04, 8'hff, "flush");
        for (int k = 0; k < 3; k++)
        begin
            fm.put(2'h0, 1, 10'h3e5);
            if (k < 2)
                fm.put(2'h0, 2, 10'h001);
        end
        rc(UERX_FLAG_ADDR, 8'hc1, 8'hc1, "cntovf");
        rc(UERX_CNTL_ADDR, 8'h05, 8'hff, "narrow");
        rc(UERX_CNTH_ADDR, 8'h00, 8'hff, "narrow");
        // manual marker and pointer moves
        es = 2'h2;
        wr(UERX_CTRL_ADDR, 8'h00);
        fm.put(2'h2, 0, 10'h011);
        fm.put(2'h2, 0, 10'h022);
        wr(UERX_CTRL_ADDR, 8'h01);
        rc(UERX_CTRL_ADDR, 8'h00, 8'hff, "rev");
        fm.put(2'h2, 0, 10'h033);
        rc(UERX_DATA_ADDR, 8'h33, 8'hff, "rewrite");
        wr(UERX_CTRL_ADDR, 8'h03);
        rc(UERX_CTRL_ADDR, 8'h03, 8'hff, "both");
        wr(UERX_CTRL_ADDR, 8'h02);
        rc(UERX_CTRL_ADDR, 8'h00, 8'hff, "adv");
        fm.put(2'h2, 0, 10'h044);
        wr(UERX_CTRL_ADDR, 8'h01);
        fm.put(2'h2, 0, 10'h055);
        rc(UERX_DATA_ADDR, 8'h55, 8'hff, "marker");
        // automatic nak, then isochronous overrun and underrun
        wr(UERX_CTRL_ADDR, 8'h84);
        fm.put(2'h2, 0, 10'h066);
        fm.put(2'h2, 1, 10'h001);
        fm.put(2'h2, 2, 10'h000);
        rc(UERX_FLAG_ADDR, 8'h08, 8'hff, "nak");
        wr(UERX_CTRL_ADDR, 8'h0c);
        for (int i = 0; i < 17; i++)
            fm.put(2'h2, 0, 10'(i));
        rc(UERX_FLAG_ADDR, 8'h04, 8'h0f, "isofull");
        fm.put(2'h0, 4, 10'h000);
        rc(UERX_FLAG_ADDR, 8'h05, 8'h0f, "sof");
        wr(UERX_CTRL_ADDR, 8'h8c);
        rd(UERX_DATA_ADDR);
        rc(UERX_FLAG_ADDR, 8'h0a, 8'hff, "isourf");
        // waited read
        wr(UERX_CTRL_ADDR, 8'ha4);
        fm.put(2'h2, 0, 10'h077);
        rc(UERX_DATA_ADDR, 8'h77, 8'hff, "waited");
        chk("wait", 8'h01, 8'(waits));
        tally_and_finish;
    end
endmodule // uerx_fifo_tb
